// file: pin_mux_pkg.sv
// package with register map, field layout and function codes of the pin mux
package pin_mux_pkg;

    // =========================================================
    // register map
    localparam logic [31:0] sel_one_addr  = 32'h5000_1208;
    localparam logic [31:0] sel_two_addr  = 32'h5000_120c;
    localparam logic [31:0] sel_one_reset = 32'h3f61_1389;
    localparam logic [31:0] sel_two_reset = 32'h002e_aa00;
    localparam int          addr_lsb      = 2;
    localparam int          word_bits     = 10;

    // =========================================================
    // field layout of the first select register
    localparam int grp0_lsb = 0;   // pair_group_zero, pins 1:0
    localparam int grp1_lsb = 4;   // pair_group_one, pins 3:2
    localparam int grp2_lsb = 8;   // pair_group_two, pins 5:4
    localparam int grp3_lsb = 12;  // pins 7:6
    localparam int grp4_lsb = 16;  // pins 9:8
    localparam int fld_w    = 4;
    // second register: pins 11:10, port c, pin 15
    localparam int grp5_lsb = 20;
    localparam int grp5_w   = 3;
    localparam int grpc_lsb = 24;
    localparam int grpc_w   = 2;
    localparam int grpj_lsb = 30;
    localparam int grpj_w   = 2;

    // =========================================================
    // function codes
    localparam logic [3:0] fn_analog     = 4'h0;
    localparam logic [3:0] fn_i2cm_grp0  = 4'h5;
    localparam logic [3:0] fn_i2cm_grp2  = 4'h5;
    localparam logic [3:0] fn_i2cm_grp4  = 4'h4;
    localparam logic [3:0] fn_analog_lo  = 4'h6;
    localparam logic [3:0] fn_analog_lo2 = 4'h7;
    localparam logic [3:0] fn_analog_g0  = 4'h7;
    localparam logic [3:0] fn_analog_g0b = 4'h8;
    localparam logic [3:0] fn_gpio_a     = 4'h8;
    localparam logic [3:0] fn_gpio_b     = 4'h9;
    localparam logic [3:0] fn_gpio_c     = 4'ha;
    localparam logic [2:0] fn_gpio5_a    = 3'h6;  // pins 11:10 plain gpio
    localparam logic [2:0] fn_gpio5_b    = 3'h7;  // pins 11:10 plain gpio
    localparam logic [1:0] fn_pin15_a    = 2'h2;
    localparam logic [1:0] fn_pin15_b    = 2'h3;

    localparam int n_pins = 16;
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // per-pin routing result
    typedef struct packed {
        logic [n_pins-1:0] use_gpio;    // pin belongs to software gpio
        logic [n_pins-1:0] use_i2cm;    // pin carries i2c master
        logic [3:0]        analog_en;   // converter input on port a 3:0
    } route_t;

    // axi-lite write request carrier
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wr_req_t;

    // function-select register pair
    typedef struct packed {
        logic [31:0] sel_one;
        logic [31:0] sel_two;
    } sel_regs_t;

    // apply byte strobes to a word
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // word address match ignoring byte offset
    function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ref_a);
        return a[31:addr_lsb] == ref_a[31:addr_lsb];
    endfunction

endpackage

// file: sel_reg_file.sv
// holds the two function-select registers with byte-lane writes
`timescale 1ns/1ps
module sel_reg_file
    import pin_mux_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire logic      wr_en,
    input  wire wr_req_t   wr_req,
    input  wire logic      rd_en,
    input  wire logic [31:0] rd_addr,
    output logic [31:0]    rd_data_r,
    output sel_regs_t      regs_r
);

    typedef struct packed {
        sel_regs_t   regs;
        logic [31:0] rdat;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // =========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        if (wr_en && addr_hit(wr_req.addr, sel_one_addr)) begin
            st_nxt.regs.sel_one = merge_strb(st_r.regs.sel_one, wr_req.data, wr_req.strb);
        end
        if (wr_en && addr_hit(wr_req.addr, sel_two_addr)) begin
            st_nxt.regs.sel_two = merge_strb(st_r.regs.sel_two, wr_req.data, wr_req.strb);
        end
        if (rd_en) begin
            if (addr_hit(rd_addr, sel_one_addr)) begin
                st_nxt.rdat = st_r.regs.sel_one;
            end else if (addr_hit(rd_addr, sel_two_addr)) begin
                st_nxt.rdat = st_r.regs.sel_two;
            end else begin
                st_nxt.rdat = 32'h0000_0000;
            end
        end
    end

    // =========================================================
    // registers, reset values loaded synchronously
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.regs.sel_one <= sel_one_reset;
            st_r.regs.sel_two <= sel_two_reset;
            st_r.rdat         <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_r = st_r.rdat;
    assign regs_r    = st_r.regs;

endmodule // sel_reg_file

// file: pair_decode.sv
// decodes one 4-bit pair field into gpio and i2c master flags
`timescale 1ns/1ps
module pair_decode
    import pin_mux_pkg::*;
#(
    parameter logic [3:0] i2cm_code = 4'h5,
    parameter logic       has_i2cm  = 1'b1
)(
    input  wire logic [3:0] field,
    output logic            gpio,
    output logic            i2cm
);

    // one field drives both pins of the pair together
    always_comb begin
        gpio = (field == fn_gpio_a) || (field == fn_gpio_b);
        i2cm = has_i2cm && (field == i2cm_code);
    end

endmodule // pair_decode

// file: pin_mux_top.sv
// pin-pair function multiplexer with axi4-lite register access
// Operation
// - sixteen muxable pins: port a 0-11, port c 6-8, port a 15
// - port a pins 0-3 can be set as converter analog inputs
// - i2c master only on port a pairs 1:0, 5:4, 9:8
// - one field value sets both pins of a pair together, except analog codes 7/8 on pins 1:0 and 6/7 on pins 3:2 (lower pin only)
// - value 5 in first register bits 11:8 puts i2c master on pins 5:4
// - group 0 is pins 1:0, group 1 pins 3:2, group 2 pins 5:4
// - first select register at 0x50001208 resets to 0x3f611389
// - second select register at 0x5000120c resets to 0x002eaa00
// - jtag clock pin usable as port a pin 15 when selected
`timescale 1ns/1ps
module pin_mux_top
    import pin_mux_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [11:0]      port_a_gpio_sel,
    output logic             pin15_gpio_sel,
    output logic [2:0]       port_c_gpio_sel,
    output logic [11:0]      port_a_i2cm_sel,
    output logic [3:0]       analog_in_en,
    output logic [31:0]      sel_one_applied,
    output logic [31:0]      sel_two_applied
);

    // =========================================================
    // module state
    typedef enum logic [2:0] {
        wr_idle = 3'b001,
        wr_exec = 3'b010,
        wr_resp = 3'b100
    } wr_state_t;

    typedef enum logic [2:0] {
        rd_idle = 3'b001,
        rd_exec = 3'b010,
        rd_resp = 3'b100
    } rd_state_t;

    typedef struct packed {
        wr_state_t   wst;
        rd_state_t   rst;
        logic        aw_have;
        logic        w_have;
        wr_req_t     wreq;
        logic [31:0] raddr;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        route_t      route;
        logic [2:0]  portc;
        logic        pin15;
        sel_regs_t   applied;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data_w;
    sel_regs_t   regs_w;
    logic [5:0]  g_gpio;
    logic [5:0]  g_i2cm;
    logic [3:0]  g5_field;

    // pins 11:10 have a 3-bit field; fold its two gpio codes onto the common one
    assign g5_field = ((regs_w.sel_two[grp5_lsb +: grp5_w] == fn_gpio5_a) ||
                       (regs_w.sel_two[grp5_lsb +: grp5_w] == fn_gpio5_b)) ? fn_gpio_a : fn_analog;

    // =========================================================
    // register storage
    sel_reg_file u_regs (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_en),
        .wr_req    (st_r.wreq),
        .rd_en     (rd_en),
        .rd_addr   (st_r.raddr),
        .rd_data_r (rd_data_w),
        .regs_r    (regs_w)
    );

    // =========================================================
    // pair decoders, group index = pin pair / 2
    pair_decode #(.i2cm_code(fn_i2cm_grp0), .has_i2cm(1'b1)) u_g0 (
        .field (regs_w.sel_one[grp0_lsb +: fld_w]),
        .gpio  (g_gpio[0]),
        .i2cm  (g_i2cm[0])
    );
    pair_decode #(.i2cm_code(fn_i2cm_grp0), .has_i2cm(1'b0)) u_g1 (
        .field (regs_w.sel_one[grp1_lsb +: fld_w]),
        .gpio  (g_gpio[1]),
        .i2cm  (g_i2cm[1])
    );
    pair_decode #(.i2cm_code(fn_i2cm_grp2), .has_i2cm(1'b1)) u_g2 (
        .field (regs_w.sel_one[grp2_lsb +: fld_w]),
        .gpio  (g_gpio[2]),
        .i2cm  (g_i2cm[2])
    );
    pair_decode #(.i2cm_code(fn_i2cm_grp0), .has_i2cm(1'b0)) u_g3 (
        .field (regs_w.sel_one[grp3_lsb +: fld_w]),
        .gpio  (g_gpio[3]),
        .i2cm  (g_i2cm[3])
    );
    pair_decode #(.i2cm_code(fn_i2cm_grp4), .has_i2cm(1'b1)) u_g4 (
        .field (regs_w.sel_one[grp4_lsb +: fld_w]),
        .gpio  (g_gpio[4]),
        .i2cm  (g_i2cm[4])
    );
    pair_decode #(.i2cm_code(fn_i2cm_grp0), .has_i2cm(1'b0)) u_g5 (
        .field (g5_field),
        .gpio  (g_gpio[5]),
        .i2cm  (g_i2cm[5])
    );

    // =========================================================
    // bus handshake and routing next state
    always_comb begin
        logic [3:0] f0;
        logic [3:0] f1;
        logic [1:0] fj;
        logic [1:0] fc;
        f0     = regs_w.sel_one[grp0_lsb +: fld_w];
        f1     = regs_w.sel_one[grp1_lsb +: fld_w];
        fj     = regs_w.sel_two[grpj_lsb +: grpj_w];
        fc     = regs_w.sel_two[grpc_lsb +: grpc_w];
        st_nxt = st_r;
        wr_en  = 1'b0;
        rd_en  = 1'b0;

        // write channel: address and data taken in either order
        case (st_r.wst)
            wr_idle: begin
                st_nxt.awready = !st_r.aw_have;
                st_nxt.wready  = !st_r.w_have;
                if (s_axi_awvalid && st_r.awready) begin
                    st_nxt.wreq.addr = s_axi_awaddr;
                    st_nxt.aw_have   = 1'b1;
                    st_nxt.awready   = 1'b0;
                end
                if (s_axi_wvalid && st_r.wready) begin
                    st_nxt.wreq.data = s_axi_wdata;
                    st_nxt.wreq.strb = s_axi_wstrb;
                    st_nxt.w_have    = 1'b1;
                    st_nxt.wready    = 1'b0;
                end
                if (st_nxt.aw_have && st_nxt.w_have) begin
                    st_nxt.awready = 1'b0;
                    st_nxt.wready  = 1'b0;
                    st_nxt.wst     = wr_exec;
                end
            end
            wr_exec: begin
                wr_en          = 1'b1;
                st_nxt.bvalid  = 1'b1;
                st_nxt.bresp   = (addr_hit(st_r.wreq.addr, sel_one_addr) ||
                                  addr_hit(st_r.wreq.addr, sel_two_addr)) ? resp_okay : resp_slverr;
                st_nxt.aw_have = 1'b0;
                st_nxt.w_have  = 1'b0;
                st_nxt.wst     = wr_resp;
            end
            wr_resp: begin
                if (s_axi_bready) begin
                    st_nxt.bvalid  = 1'b0;
                    st_nxt.awready = 1'b1;
                    st_nxt.wready  = 1'b1;
                    st_nxt.wst     = wr_idle;
                end
            end
            default: begin
                st_nxt.wst = wr_idle;
            end
        endcase

        // read channel: one cycle to fetch, then answer
        case (st_r.rst)
            rd_idle: begin
                st_nxt.arready = 1'b1;
                if (s_axi_arvalid && st_r.arready) begin
                    st_nxt.raddr   = s_axi_araddr;
                    st_nxt.arready = 1'b0;
                    st_nxt.rst     = rd_exec;
                end
            end
            rd_exec: begin
                rd_en      = 1'b1;
                st_nxt.rst = rd_resp;
            end
            rd_resp: begin
                if (!st_r.rvalid) begin
                    st_nxt.rvalid = 1'b1;
                    st_nxt.rdata  = rd_data_w;
                    st_nxt.rresp  = (addr_hit(st_r.raddr, sel_one_addr) ||
                                     addr_hit(st_r.raddr, sel_two_addr)) ? resp_okay : resp_slverr;
                end else if (s_axi_rready) begin
                    st_nxt.rvalid  = 1'b0;
                    st_nxt.arready = 1'b1;
                    st_nxt.rst     = rd_idle;
                end
            end
            default: begin
                st_nxt.rst = rd_idle;
            end
        endcase

        // pin routing from current register contents
        for (int g = 0; g < 6; g++) begin
            st_nxt.route.use_gpio[2*g +: 2] = {2{g_gpio[g]}};
            st_nxt.route.use_i2cm[2*g +: 2] = {2{g_i2cm[g]}};
        end
        st_nxt.route.use_gpio[15:12] = 4'h0;
        st_nxt.route.use_i2cm[15:12] = 4'h0;
        // jtag clock pin becomes port a pin 15
        st_nxt.pin15 = (fj == fn_pin15_a) || (fj == fn_pin15_b);
        // port c pins take software gpio when their field is non-zero
        st_nxt.portc = {3{fc != 2'h0}};
        // converter inputs on port a 3:0
        st_nxt.route.analog_en[1:0] = (f0 == fn_analog) ? 2'b11 :
                                      ((f0 == fn_analog_g0 || f0 == fn_analog_g0b) ? 2'b01 : 2'b00);
        st_nxt.route.analog_en[3:2] = (f1 == fn_analog) ? 2'b11 :
                                      ((f1 == fn_analog_lo || f1 == fn_analog_lo2) ? 2'b01 : 2'b00);
        st_nxt.applied = regs_w;
    end

    // =========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.wst     <= wr_idle;
            st_r.rst     <= rd_idle;
            st_r.applied <= {sel_one_reset, sel_two_reset};
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs, all from flip-flops
    assign s_axi_awready   = st_r.awready;
    assign s_axi_wready    = st_r.wready;
    assign s_axi_bvalid    = st_r.bvalid;
    assign s_axi_bresp     = st_r.bresp;
    assign s_axi_arready   = st_r.arready;
    assign s_axi_rvalid    = st_r.rvalid;
    assign s_axi_rresp     = st_r.rresp;
    assign s_axi_rdata     = st_r.rdata;
    assign port_a_gpio_sel = st_r.route.use_gpio[11:0];
    assign port_a_i2cm_sel = st_r.route.use_i2cm[11:0];
    assign analog_in_en    = st_r.route.analog_en;
    assign pin15_gpio_sel  = st_r.pin15;
    assign port_c_gpio_sel = st_r.portc;
    assign sel_one_applied = st_r.applied.sel_one;
    assign sel_two_applied = st_r.applied.sel_two;

endmodule // pin_mux_top

// file: pin_mux_top_assertions.sv
// concurrent checks on the pin mux top ports
`timescale 1ns/1ps
module pin_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [11:0] port_a_gpio_sel,
    input wire logic [11:0] port_a_i2cm_sel,
    input wire logic [3:0]  analog_in_en,
    input wire logic        pin15_gpio_sel,
    input wire logic [2:0]  port_c_gpio_sel,
    input wire logic [31:0] sel_one_applied,
    input wire logic [31:0] sel_two_applied
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // cycles since reset, pins settle from the second
    logic [1:0] up_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    // ==========================================
    // pins and the applied copy move on the same edge, one after the write
    a_grp0_i2cm:
        assert property (up_r[1] |-> port_a_i2cm_sel[1:0] == {2{sel_one_applied[3:0] == 4'h5}})
        else $error("pins 1:0 i2c select wrong");
    a_grp2_i2cm:
        assert property (up_r[1] |-> port_a_i2cm_sel[5:4] == {2{sel_one_applied[11:8] == 4'h5}})
        else $error("pins 5:4 i2c select wrong");
    a_grp4_i2cm:
        assert property (up_r[1] |-> port_a_i2cm_sel[9:8] == {2{sel_one_applied[19:16] == 4'h4}})
        else $error("pins 9:8 i2c select wrong");
    a_no_i2cm_else:
        assert property (up_r[1] |-> {port_a_i2cm_sel[11:10], port_a_i2cm_sel[7:6], port_a_i2cm_sel[3:2]} == 6'h00)
        else $error("i2c master on a pair without it");
    a_pair_gpio:
        assert property (port_a_gpio_sel[4] == port_a_gpio_sel[5] && port_a_gpio_sel[8] == port_a_gpio_sel[9])
        else $error("pair pins split");
    a_analog_sel:
        assert property (up_r[1] |-> analog_in_en[1] == (sel_one_applied[3:0] == 4'h0)
                         && analog_in_en[3] == (sel_one_applied[7:4] == 4'h0))
        else $error("analog enable wrong");
    a_pin15_sel:
        assert property (up_r[1] |-> pin15_gpio_sel == sel_two_applied[31])
        else $error("pin 15 select wrong");
    a_portc_sel:
        assert property (up_r[1] |-> port_c_gpio_sel == {3{|sel_two_applied[25:24]}})
        else $error("port c select wrong");
    a_reset_vals:
        assert property ($rose(aresetn) |-> ##1 (sel_one_applied == sel_one_reset && sel_two_applied == sel_two_reset))
        else $error("reset values wrong");
    a_read_latency:
        assert property (s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid)
        else $error("read answer late");
    a_b_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // main scenarios reached
    c_grp2_i2c: cover property (port_a_i2cm_sel[5:4] == 2'h3);
    c_analog: cover property (analog_in_en[3:2] == 2'h3);
    c_pin15: cover property (pin15_gpio_sel);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);
endmodule // pin_mux_checker

bind pin_mux_top pin_mux_checker chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_a_gpio_sel,
    .port_a_i2cm_sel, .analog_in_en, .pin15_gpio_sel, .port_c_gpio_sel, .sel_one_applied, .sel_two_applied);

// file: pin_owner_model.sv
// pad-side model of port a pins driven by the mux selects
`timescale 1ns/1ps
module pin_owner_model
    import pin_mux_pkg::*;
(
    input  wire logic [11:0] gpio_sel,
    input  wire logic [11:0] i2cm_sel,
    input  wire logic [3:0]  analog_en,
    input  wire logic [11:0] gpio_out,
    input  wire logic [11:0] i2c_out,
    output logic [11:0]      pad,
    output logic             clash
);
    // ==========================================
    // pad level: i2c master, then gpio, else pull-down
    always_comb begin
        for (int k = 0; k < 12; k++) begin
            if (i2cm_sel[k]) begin
                pad[k] = i2c_out[k];
            end else if (gpio_sel[k]) begin
                pad[k] = gpio_out[k];
            end else begin
                pad[k] = 1'b0; // input_with_pulldown
            end
        end
    end
    // one owner per pin, analog pins carry no digital function
    assign clash = |(gpio_sel & i2cm_sel) | |(analog_en & (gpio_sel[3:0] | i2cm_sel[3:0]));
endmodule // pin_owner_model

// file: tb_pin_mux_top.sv
// self-checking bench for the pin mux over axi4-lite
`timescale 1ns/1ps
module tb_pin_mux_top
    import pin_mux_pkg::*;
;
    localparam logic [11:0] gpio_drv = 12'h5a5;
    localparam logic [11:0] i2c_drv  = 12'h2b3;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d2;
    logic [31:0] sel_one_applied, sel_two_applied;
    logic [3:0]  s_axi_wstrb = 4'h0, analog_in_en;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin15_gpio_sel, clash;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] port_a_gpio_sel, port_a_i2cm_sel, pad;
    logic [2:0]  port_c_gpio_sel;
    int          fails = 0;
    int          comparisons = 0;

    // ==========================================
    // clock, design and pad model
    always #5 aclk = ~aclk;
    pin_mux_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port_a_gpio_sel, .pin15_gpio_sel, .port_c_gpio_sel, .port_a_i2cm_sel,
        .analog_in_en, .sel_one_applied, .sel_two_applied);
    pin_owner_model peer_u (.gpio_sel(port_a_gpio_sel), .i2cm_sel(port_a_i2cm_sel), .analog_en(analog_in_en),
        .gpio_out(gpio_drv), .i2c_out(i2c_drv), .pad(pad), .clash(clash));

    // ==========================================
    // comparison, bus and pin tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw;
        logic w;
        logic b;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awready && !aw) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                b = 1'b1;
                s_axi_bready <= 1'b0;
                chk(32'(s_axi_bresp), 32'(er), "write response");
            end
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic r;
        r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r) begin
            @(posedge aclk);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                r = 1'b1;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, exp, "read data");
                chk(32'(s_axi_rresp), 32'(er), "read response");
            end
        end
    endtask
    task automatic pins(input logic [9:0] g, input logic [11:0] i, input logic [3:0] an);
        @(posedge aclk);
        chk(32'(port_a_gpio_sel[9:0]), 32'(g), "gpio pins");
        chk(32'(port_a_i2cm_sel), 32'(i), "i2c pins");
        chk(32'(analog_in_en), 32'(an), "analog pins");
        chk(32'(pad[9:0]), 32'(10'((i & i2c_drv) | (~i & {2'h0, g} & gpio_drv))), "pad levels");
        chk(32'(clash), 32'h0, "pin owner clash");
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial begin
        do_reset();
        rd(sel_one_addr, sel_one_reset, resp_okay);
        rd(sel_two_addr, sel_two_reset, resp_okay);
        pins(10'h00f, 12'h000, 4'h0);
        chk(32'({pin15_gpio_sel, port_c_gpio_sel}), 32'h0, "reset pin 15 and port c");
        $display("test reset_values done");
        wr(sel_one_addr, 32'h0000_0500, 4'h2, resp_okay);
        rd(sel_one_addr, 32'h3f61_0589, resp_okay);
        pins(10'h00f, 12'h030, 4'h0);
        chk(sel_one_applied, 32'h3f61_0589, "applied copy one");
        $display("test i2c_on_group_two done");
        wr(sel_one_addr, 32'h0004_5005, 4'hf, resp_okay);
        rd(sel_one_addr, 32'h0004_5005, resp_okay);
        pins(10'h000, 12'h303, 4'hc);
        $display("test i2c_pairs_and_analog done");
        wr(sel_one_addr, 32'h0009_9999, 4'hf, resp_okay);
        pins(10'h3ff, 12'h000, 4'h0);
        $display("test all_gpio done");
        for (int v = 0; v < 4; v++) begin
            d2 = {v[1:0], 4'h0, 2'h1, 8'h6e, 16'haa00};
            wr(sel_two_addr, d2, 4'hc, resp_okay);
            rd(sel_two_addr, d2, resp_okay);
            chk(sel_two_applied, d2, "applied copy two");
            chk(32'(port_a_gpio_sel[11:10]), 32'h3, "pins 11:10 gpio");
            chk(32'(pin15_gpio_sel), 32'(v[1]), "pin 15 select");
            chk(32'(port_c_gpio_sel), 32'h7, "port c select");
        end
        $display("test pin15_and_port_c done");
        wr(32'h5000_1210, 32'hffff_ffff, 4'hf, resp_slverr);
        rd(32'h5000_1210, 32'h0, resp_slverr);
        rd(sel_one_addr, 32'h0009_9999, resp_okay);
        $display("test unmapped done");
        do_reset();
        rd(sel_one_addr, sel_one_reset, resp_okay);
        rd(sel_two_addr, sel_two_reset, resp_okay);
        pins(10'h00f, 12'h000, 4'h0);
        $display("test mid_run_reset done");
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        #100us;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // tb_pin_mux_top
